// >>> hw/lpmc_pkg.sv
// Package with register map, fields, states and timing for the mode control.
package lpmc_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LPMC_SUPPLY_CTRL_OFS = 8'h00;
  localparam logic [7:0] LPMC_MAIN_OSC_OFS = 8'h04;
  localparam logic [7:0] LPMC_FAST_STARTUP_OFS = 8'h08;
  localparam logic [7:0] LPMC_WAKE_ENABLE_OFS = 8'h0C;
  localparam logic [7:0] LPMC_CLOCK_CTRL_OFS = 8'h10;
  localparam logic [7:0] LPMC_STATUS_OFS = 8'h14;
  localparam logic [7:0] LPMC_CORE_CTRL_OFS = 8'h18;
  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LPMC_REG_OFF_BIT = 0;
  localparam int LPMC_CORE_REG_DIS_BIT = 1;
  localparam int LPMC_WAIT_REQ_BIT = 0;
  localparam int LPMC_FAST_RC_EN_BIT = 1;
  localparam int LPMC_LP_SELECT_BIT = 0;
  localparam int LPMC_FLASH_LP_LSB = 1;
  localparam int LPMC_FLASH_WS_LSB = 4;
  localparam int LPMC_WAKE_SUPPLY_BIT = 16;
  localparam int LPMC_WAKE_CAL_BIT = 17;
  localparam int LPMC_WAKE_TIMER_BIT = 18;
  localparam int LPMC_WAKE_USB_BIT = 19;
  localparam int LPMC_CLK_SRC_LSB = 0;
  localparam int LPMC_PERIPH_GATE_LSB = 8;
  localparam int LPMC_DEEP_SLEEP_BIT = 0;
  localparam int LPMC_CORE_SPARE_BIT = 1;
  // ---------------------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------------------
  localparam logic [1:0] LPMC_SRC_FAST_RC = 2'h0;
  localparam logic [1:0] LPMC_SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] LPMC_SRC_PLL = 2'h2;
  localparam logic [31:0] LPMC_CLOCK_CTRL_RST = 32'h0000FF00;
  localparam logic [31:0] LPMC_MAIN_OSC_RST = 32'h00000002;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int LPMC_CLK_MHZ = 250;
  localparam int LPMC_REG_START_US = 300;
  localparam int LPMC_REG_START_CYC = LPMC_REG_START_US * LPMC_CLK_MHZ;
  localparam int LPMC_DEBOUNCE_CYC = 4;
  typedef enum logic [2:0] {
    LPMC_ACTIVE, LPMC_SLEEP, LPMC_WAIT, LPMC_BACKUP, LPMC_WAKE_START
  } lpmc_state_e;
endpackage : lpmc_pkg

// >>> hw/lpmc_top.sv
// Low-power mode controller with AXI4-Lite register access.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Active mode clocks core from fast RC, crystal or PLL; peripheral gates.
// - Backup entered only with deep-sleep flag and regulator-off request both 1.
// - Backup turns off regulators, transceiver and core supply; backup region runs.
// - Backup left on enabled wake pin transition, supply, calendar or timer alarm.
// - Every wake source has an enable; each part switched separately.
// - Any low-power mode turns the line transceiver off.
// - Wait stops core, peripheral and memory clocks, supplies stay on.
// - Wait entered with wait request, low-power select 1, flash field 00 or 01.
// - Wait wakes on fast pins, calendar, timer or USB resume without reset.
// - Sleep stops only the core clock; peripheral clocks may run.
// - Sleep entered on wait-for-interrupt with low-power select 0; interrupts wake.
// - After any wake the core runs from the fast RC oscillator.
// - Software may disable the core regulator independently of backup mode.
// - Leaving backup, core is held for at least 300 us of regulator start.
module lpmc_top #(
  parameter int WAKE_PINS = 16,
  parameter int REG_START_CYC = lpmc_pkg::LPMC_REG_START_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor events
  input wire logic wait_for_interrupt_instr,
  input wire logic irq_pending,
  // Wake events
  input wire logic [WAKE_PINS-1:0] wake_pins,
  input wire logic supply_monitor_alarm,
  input wire logic calendar_alarm,
  input wire logic real_time_timer_alarm,
  input wire logic usb_resume,
  // Clock and power controls
  output logic [1:0] core_clk_src,
  output logic core_clk_en,
  output logic [7:0] periph_clk_en,
  output logic mem_clk_en,
  output logic regulator_en,
  output logic core_supply_en,
  output logic transceiver_en,
  output logic core_reset,
  output logic [2:0] power_mode
);
  import lpmc_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [31:0] supply_ctrl_reg, supply_ctrl_next;
  logic [31:0] main_osc_reg, main_osc_next;
  logic [31:0] fast_startup_reg, fast_startup_next;
  logic [31:0] wake_en_reg, wake_en_next;
  logic [31:0] clock_ctrl_reg, clock_ctrl_next;
  logic [31:0] core_ctrl_reg, core_ctrl_next;
  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // Mode sequencer state.
  lpmc_state_e state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic [WAKE_PINS-1:0] pin_last_reg, pin_last_next;
  logic [WAKE_PINS-1:0] pin_stable_reg, pin_stable_next;
  logic [2:0] db_cnt_reg [WAKE_PINS];
  logic [2:0] db_cnt_next [WAKE_PINS];
  logic mclk_ready_reg, mclk_ready_next;
  logic [WAKE_PINS-1:0] pin_event;
  logic wake_backup, wake_wait, do_write;
  logic [1:0] flash_lp;
  logic [31:0] wmask, status_word;

  assign flash_lp = fast_startup_reg[LPMC_FLASH_LP_LSB +: 2];

  // ---------------------------------------------------------------------------
  // Wake pin debouncing
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_last_next = wake_pins;
    pin_stable_next = pin_stable_reg;
    pin_event = '0;
    for (int i = 0; i < WAKE_PINS; i++) begin
      db_cnt_next[i] = db_cnt_reg[i];
      if (wake_pins[i] != pin_last_reg[i]) begin
        db_cnt_next[i] = 3'h0;
      end else if (wake_pins[i] != pin_stable_reg[i]) begin
        if (db_cnt_reg[i] == 3'(LPMC_DEBOUNCE_CYC - 1)) begin
          pin_stable_next[i] = wake_pins[i];
          pin_event[i] = 1'b1;
        end else begin
          db_cnt_next[i] = db_cnt_reg[i] + 3'h1;
        end
      end
    end
  end

  // Enabled wake sources, each gated by its own bit.
  always_comb begin
    wake_backup = |(pin_event & wake_en_reg[WAKE_PINS-1:0])
      | (supply_monitor_alarm & wake_en_reg[LPMC_WAKE_SUPPLY_BIT])
      | (calendar_alarm & wake_en_reg[LPMC_WAKE_CAL_BIT])
      | (real_time_timer_alarm & wake_en_reg[LPMC_WAKE_TIMER_BIT]);
    wake_wait = |(pin_event & wake_en_reg[WAKE_PINS-1:0])
      | (calendar_alarm & wake_en_reg[LPMC_WAKE_CAL_BIT])
      | (real_time_timer_alarm & wake_en_reg[LPMC_WAKE_TIMER_BIT])
      | (usb_resume & wake_en_reg[LPMC_WAKE_USB_BIT]);
  end

  // ---------------------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    mclk_ready_next = mclk_ready_reg;
    unique case (state_reg)
      LPMC_ACTIVE: begin
        mclk_ready_next = 1'b1;
        if (core_ctrl_reg[LPMC_DEEP_SLEEP_BIT] &&
            supply_ctrl_reg[LPMC_REG_OFF_BIT]) begin
          state_next = LPMC_BACKUP;
        end else if (main_osc_reg[LPMC_WAIT_REQ_BIT] &&
                     fast_startup_reg[LPMC_LP_SELECT_BIT] &&
                     !flash_lp[1]) begin
          state_next = LPMC_WAIT;
          mclk_ready_next = 1'b0;
        end else if (wait_for_interrupt_instr &&
                     !fast_startup_reg[LPMC_LP_SELECT_BIT]) begin
          state_next = LPMC_SLEEP;
        end
      end
      LPMC_SLEEP: begin
        if (irq_pending) begin
          state_next = LPMC_ACTIVE;
        end
      end
      LPMC_WAIT: begin
        if (wake_wait) begin
          state_next = LPMC_ACTIVE;
        end
      end
      LPMC_BACKUP: begin
        if (wake_backup) begin
          state_next = LPMC_WAKE_START;
          timer_next = '0;
        end
      end
      LPMC_WAKE_START: begin
        if (timer_reg == 32'(REG_START_CYC - 1)) begin
          state_next = LPMC_ACTIVE;
        end else begin
          timer_next = timer_reg + 32'h1;
        end
      end
      default: state_next = LPMC_ACTIVE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_comb begin
    status_word = '0;
    status_word[2:0] = state_reg;
    status_word[3] = mclk_ready_reg;
  end

  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    supply_ctrl_next = supply_ctrl_reg;
    main_osc_next = main_osc_reg;
    fast_startup_next = fast_startup_reg;
    wake_en_next = wake_en_reg;
    clock_ctrl_next = clock_ctrl_reg;
    core_ctrl_next = core_ctrl_reg;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_reg[b]}};
    end
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    do_write = aw_hold_reg && w_hold_reg;
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'h0;
      unique case ({awaddr_reg[7:2], 2'h0})
        LPMC_SUPPLY_CTRL_OFS: supply_ctrl_next =
          (supply_ctrl_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_MAIN_OSC_OFS: main_osc_next =
          (main_osc_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_FAST_STARTUP_OFS: fast_startup_next =
          (fast_startup_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_WAKE_ENABLE_OFS: wake_en_next =
          (wake_en_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_CLOCK_CTRL_OFS: clock_ctrl_next =
          (clock_ctrl_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_CORE_CTRL_OFS: core_ctrl_next =
          (core_ctrl_reg & ~wmask) | (wdata_reg & wmask);
        LPMC_STATUS_OFS: bresp_next = 2'h0;
        default: bresp_next = 2'h2;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Hardware changes below win over a software write in the same cycle.
    if (state_reg == LPMC_ACTIVE && state_next != LPMC_ACTIVE) begin
      clock_ctrl_next[LPMC_CLK_SRC_LSB +: 2] = LPMC_SRC_FAST_RC;
      core_ctrl_next[LPMC_CORE_SPARE_BIT] = 1'b0;
    end
    if (state_next == LPMC_WAIT && state_reg != LPMC_WAIT) begin
      main_osc_next[LPMC_FAST_RC_EN_BIT] = 1'b0;
    end
    if (state_reg == LPMC_WAIT && state_next == LPMC_ACTIVE) begin
      main_osc_next[LPMC_WAIT_REQ_BIT] = 1'b0;
      main_osc_next[LPMC_FAST_RC_EN_BIT] = 1'b1;
    end
    if (state_reg == LPMC_WAKE_START && state_next == LPMC_ACTIVE) begin
      supply_ctrl_next[LPMC_REG_OFF_BIT] = 1'b0;
      core_ctrl_next[LPMC_DEEP_SLEEP_BIT] = 1'b0;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      unique case ({s_axi_araddr[7:2], 2'h0})
        LPMC_SUPPLY_CTRL_OFS: rdata_next = supply_ctrl_reg;
        LPMC_MAIN_OSC_OFS: rdata_next = main_osc_reg;
        LPMC_FAST_STARTUP_OFS: rdata_next = fast_startup_reg;
        LPMC_WAKE_ENABLE_OFS: rdata_next = wake_en_reg;
        LPMC_CLOCK_CTRL_OFS: rdata_next = clock_ctrl_reg;
        LPMC_STATUS_OFS: rdata_next = status_word;
        LPMC_CORE_CTRL_OFS: rdata_next = core_ctrl_reg;
        default: begin
          rdata_next = '0;
          rresp_next = 2'h2;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= LPMC_ACTIVE;
      timer_reg <= '0;
      mclk_ready_reg <= 1'b1;
      pin_last_reg <= '0;
      pin_stable_reg <= '0;
      for (int i = 0; i < WAKE_PINS; i++) begin
        db_cnt_reg[i] <= 3'h0;
      end
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
      supply_ctrl_reg <= 32'h00000000;
      main_osc_reg <= LPMC_MAIN_OSC_RST;
      fast_startup_reg <= 32'h00000000;
      wake_en_reg <= 32'h00000000;
      clock_ctrl_reg <= LPMC_CLOCK_CTRL_RST;
      core_ctrl_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      mclk_ready_reg <= mclk_ready_next;
      pin_last_reg <= pin_last_next;
      pin_stable_reg <= pin_stable_next;
      db_cnt_reg <= db_cnt_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      supply_ctrl_reg <= supply_ctrl_next;
      main_osc_reg <= main_osc_next;
      fast_startup_reg <= fast_startup_next;
      wake_en_reg <= wake_en_next;
      clock_ctrl_reg <= clock_ctrl_next;
      core_ctrl_reg <= core_ctrl_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Power and clock outputs
  // ---------------------------------------------------------------------------
  always_comb begin
    core_clk_src = clock_ctrl_reg[LPMC_CLK_SRC_LSB +: 2];
    periph_clk_en = clock_ctrl_reg[LPMC_PERIPH_GATE_LSB +: 8];
    core_clk_en = (state_reg == LPMC_ACTIVE);
    mem_clk_en = (state_reg == LPMC_ACTIVE) || (state_reg == LPMC_SLEEP);
    if (state_reg == LPMC_WAIT || state_reg == LPMC_BACKUP ||
        state_reg == LPMC_WAKE_START) begin
      periph_clk_en = 8'h00;
      mem_clk_en = 1'b0;
    end
    regulator_en = (state_reg != LPMC_BACKUP) &&
      !supply_ctrl_reg[LPMC_CORE_REG_DIS_BIT];
    core_supply_en = (state_reg != LPMC_BACKUP);
    transceiver_en = (state_reg == LPMC_ACTIVE);
    core_reset = (state_reg == LPMC_BACKUP) ||
      (state_reg == LPMC_WAKE_START);
    power_mode = state_reg;
  end
endmodule : lpmc_top
`default_nettype wire

// >>> sim/lpmc_props.sv
// Concurrent checks on the mode controller's clock and power outputs.
`timescale 1ns/10ps
`default_nettype none
module lpmc_props
  import lpmc_pkg::*;
#(
  parameter int REG_START_CYC = lpmc_pkg::LPMC_REG_START_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Processor events
  input wire logic irq_pending,
  // Clock and power controls
  input wire logic [1:0] core_clk_src,
  input wire logic core_clk_en,
  input wire logic [7:0] periph_clk_en,
  input wire logic mem_clk_en,
  input wire logic regulator_en,
  input wire logic core_supply_en,
  input wire logic transceiver_en,
  input wire logic core_reset,
  input wire logic [2:0] power_mode
);
  // ---------------------------------------------------------------
  // Regulator start hold counter
  // ---------------------------------------------------------------
  int hold_reg;
  int hold_next;
  always_comb begin
    hold_next = (power_mode == LPMC_WAKE_START) ? hold_reg + 1 : 0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 0;
    end else begin
      hold_reg <= hold_next;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_backup_left;
    power_mode == LPMC_BACKUP ##1 power_mode != LPMC_BACKUP;
  endsequence
  sequence s_wait_left;
    power_mode == LPMC_WAIT ##1 power_mode != LPMC_WAIT;
  endsequence
  active_run_a: assert property (
    power_mode == LPMC_ACTIVE |-> core_clk_en && core_supply_en &&
      !core_reset && core_clk_src != 2'h3)
    else $error("active mode outputs wrong");
  backup_off_a: assert property (
    power_mode == LPMC_BACKUP |-> !regulator_en && !core_supply_en &&
      !transceiver_en && !core_clk_en)
    else $error("backup left a supply on");
  lp_xcvr_off_a: assert property (
    power_mode inside {LPMC_SLEEP, LPMC_WAIT, LPMC_BACKUP} |->
      !transceiver_en)
    else $error("transceiver on in low power");
  wait_gated_a: assert property (
    power_mode == LPMC_WAIT |-> !core_clk_en && !mem_clk_en &&
      periph_clk_en == 8'h00 && core_supply_en)
    else $error("wait mode clocks or supply wrong");
  wait_exit_a: assert property (
    s_wait_left |-> power_mode == LPMC_ACTIVE && !core_reset)
    else $error("wait exit not to running core");
  sleep_core_a: assert property (
    power_mode == LPMC_SLEEP |-> !core_clk_en && mem_clk_en &&
      core_supply_en)
    else $error("sleep gates more than core");
  sleep_wake_a: assert property (
    power_mode == LPMC_SLEEP && irq_pending |-> ##[1:4]
      power_mode == LPMC_ACTIVE)
    else $error("interrupt did not end sleep");
  wake_fast_rc_a: assert property (
    power_mode == LPMC_ACTIVE && $past(power_mode) != LPMC_ACTIVE |->
      core_clk_src == LPMC_SRC_FAST_RC)
    else $error("woke on other than fast RC");
  backup_exit_a: assert property (
    s_backup_left |-> power_mode == LPMC_WAKE_START)
    else $error("backup exit skipped start hold");
  start_reset_a: assert property (
    power_mode == LPMC_WAKE_START |-> core_reset)
    else $error("core released during start hold");
  hold_len_a: assert property (
    power_mode != LPMC_WAKE_START &&
      $past(power_mode) == LPMC_WAKE_START |-> hold_reg >= REG_START_CYC)
    else $error("regulator start hold too short");
endmodule : lpmc_props
bind lpmc_top lpmc_props #(.REG_START_CYC(REG_START_CYC)) u_props (
  .aclk, .aresetn, .irq_pending, .core_clk_src, .core_clk_en,
  .periph_clk_en, .mem_clk_en, .regulator_en, .core_supply_en,
  .transceiver_en, .core_reset, .power_mode
);
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the low-power mode controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lpmc_pkg::*;
  localparam int RSC = 20;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_clk_src;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic wait_for_interrupt_instr, irq_pending, supply_monitor_alarm;
  logic calendar_alarm, real_time_timer_alarm, usb_resume;
  logic [15:0] wake_pins;
  logic core_clk_en, mem_clk_en, regulator_en, core_supply_en;
  logic transceiver_en, core_reset;
  logic [7:0] periph_clk_en;
  logic [2:0] power_mode;
  int errors, n_tests, i, cnt;
  lpmc_top #(.WAKE_PINS(16), .REG_START_CYC(RSC)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wait_for_interrupt_instr,
    .irq_pending, .wake_pins, .supply_monitor_alarm, .calendar_alarm,
    .real_time_timer_alarm, .usb_resume, .core_clk_src, .core_clk_en,
    .periph_clk_en, .mem_clk_en, .regulator_en, .core_supply_en,
    .transceiver_en, .core_reset, .power_mode
  );
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bvalid), 32'h1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rvalid), 32'h1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : axi_rd
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (power_mode !== m && n < 50) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(power_mode), 32'(m));
  endtask : wait_mode
  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {wait_for_interrupt_instr, irq_pending, supply_monitor_alarm} = '0;
    {calendar_alarm, real_time_timer_alarm, usb_resume} = '0;
    wake_pins = 16'h0000;
    tick(12);
    aresetn <= 1'b1;
    tick(1);
    chk({power_mode, periph_clk_en, transceiver_en}, 32'h1FF);
    axi_rd(LPMC_SUPPLY_CTRL_OFS, 32'h0, 2'h0);
    axi_rd(LPMC_MAIN_OSC_OFS, LPMC_MAIN_OSC_RST, 2'h0);
    axi_rd(LPMC_FAST_STARTUP_OFS, 32'h0, 2'h0);
    axi_rd(LPMC_WAKE_ENABLE_OFS, 32'h0, 2'h0);
    axi_rd(LPMC_CLOCK_CTRL_OFS, LPMC_CLOCK_CTRL_RST, 2'h0);
    axi_rd(LPMC_CORE_CTRL_OFS, 32'h0, 2'h0);
    axi_rd(8'h1C, 32'h0, 2'h2);
    axi_wr(8'h1C, 32'hFFFFFFFF, 2'h2);
    axi_wr(LPMC_STATUS_OFS, 32'h7, 2'h0);
    axi_rd(LPMC_STATUS_OFS, 32'h8, 2'h0);
    for (i = 0; i < 3; i++) begin
      axi_wr(LPMC_CLOCK_CTRL_OFS, 32'h0000A500 | 32'(i), 2'h0);
      chk({periph_clk_en, core_clk_src}, 32'(i) | 32'h294);
    end
    axi_wr(LPMC_SUPPLY_CTRL_OFS, 32'h2, 2'h0);
    tick(3);
    chk({power_mode, regulator_en}, 32'h0);
    axi_wr(LPMC_SUPPLY_CTRL_OFS, 32'h0, 2'h0);
    chk(32'(regulator_en), 32'h1);
    axi_wr(LPMC_CLOCK_CTRL_OFS, 32'h00003C01, 2'h0);
    wait_for_interrupt_instr <= 1'b1;
    wait_mode(LPMC_SLEEP);
    chk({core_clk_en, mem_clk_en, periph_clk_en}, 32'h13C);
    chk(32'(transceiver_en), 32'h0);
    irq_pending <= 1'b1;
    wait_for_interrupt_instr <= 1'b0;
    wait_mode(LPMC_ACTIVE);
    irq_pending <= 1'b0;
    chk(32'(core_clk_src), 32'(LPMC_SRC_FAST_RC));
    axi_wr(LPMC_WAKE_ENABLE_OFS, 32'h000FFFFF, 2'h0);
    axi_rd(LPMC_WAKE_ENABLE_OFS, 32'h000FFFFF, 2'h0);
    axi_wr(LPMC_CLOCK_CTRL_OFS, 32'h0000FF00, 2'h0);
    for (i = 0; i < 4; i++) begin
      axi_wr(LPMC_FAST_STARTUP_OFS, 32'(i * 2 + 1), 2'h0);
      axi_wr(LPMC_MAIN_OSC_OFS, 32'h3, 2'h0);
      tick(3);
      if (i < 2) begin
        chk(32'(power_mode), 32'(LPMC_WAIT));
        chk({core_clk_en, mem_clk_en, periph_clk_en, core_supply_en,
             regulator_en, transceiver_en}, 32'h6);
        axi_rd(LPMC_STATUS_OFS, 32'h2, 2'h0);
        axi_rd(LPMC_MAIN_OSC_OFS, 32'h1, 2'h0);
        {calendar_alarm, usb_resume} <= (i == 0) ? 2'h1 : 2'h2;
        wait_mode(LPMC_ACTIVE);
        {calendar_alarm, usb_resume} <= 2'h0;
        chk(32'(core_reset), 32'h0);
        axi_rd(LPMC_MAIN_OSC_OFS, 32'h2, 2'h0);
      end else begin
        chk(32'(power_mode), 32'(LPMC_ACTIVE));
        axi_wr(LPMC_MAIN_OSC_OFS, 32'h2, 2'h0);
      end
    end
    axi_wr(LPMC_FAST_STARTUP_OFS, 32'h0, 2'h0);
    axi_wr(LPMC_WAKE_ENABLE_OFS, 32'h00000008, 2'h0);
    axi_wr(LPMC_SUPPLY_CTRL_OFS, 32'h1, 2'h0);
    tick(3);
    chk(32'(power_mode), 32'(LPMC_ACTIVE));
    axi_wr(LPMC_SUPPLY_CTRL_OFS, 32'h0, 2'h0);
    axi_wr(LPMC_CORE_CTRL_OFS, 32'h1, 2'h0);
    axi_wr(LPMC_SUPPLY_CTRL_OFS, 32'h1, 2'h0);
    wait_mode(LPMC_BACKUP);
    chk({regulator_en, core_supply_en, transceiver_en}, 32'h0);
    real_time_timer_alarm <= 1'b1;
    tick(8);
    chk(32'(power_mode), 32'(LPMC_BACKUP));
    real_time_timer_alarm <= 1'b0;
    wake_pins <= 16'h0008;
    wait_mode(LPMC_WAKE_START);
    chk(32'(core_reset), 32'h1);
    cnt = 0;
    while (power_mode === LPMC_WAKE_START && cnt < 200) begin
      @(posedge aclk);
      cnt++;
    end
    chk(32'(cnt >= RSC), 32'h1);
    chk({power_mode, core_reset, core_clk_src}, 32'h0);
    axi_rd(LPMC_SUPPLY_CTRL_OFS, 32'h0, 2'h0);
    axi_rd(LPMC_CORE_CTRL_OFS, 32'h0, 2'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
